// [rtl/capacity_learning_core.v]
// Learned capacity, nominal capacity and discharge tally counters.
// Assumes one-cycle event pulses from the analog front end, in sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "capacity_learning_consts.vh"

// Notes on behaviour
// - Power-up or battery replacement loads learned capacity from strap full count.
// - First valid charge after qualified empty copies tally into learned capacity.
// - A charge over two updates between full and empty blocks learning.
// - Learning needs self-discharge below six percent of nominal capacity.
// - Learning needs non-negative temperature when first empty was reached.
// - A discharge-qualified flag must be set before any learning update.
// - Tally below 0.94 of learned capacity limits update to 0.94 of it.
// - Relative percentage uses learned capacity as full scale.
// - First two straps pick one of nine initial full counts.
// - Third and fourth straps pick one of six count scales.
// - Fifth strap picks anode type and self-discharge enable.
// - Display pin picks LEDs off, on while charging, or four seconds.
// - Nominal counter rises on charge to learned capacity, falls to zero.
// - Nominal counter clears at init and first valid charge after empty.
// - Tally counts self-discharge only while nominal counter is nonzero.
// - Tally clears whenever nominal counter equals learned capacity.
// - Tally saturates at FFh instead of wrapping.
// - Scaled energy is given as high and low bytes.
// - Valid charge is two consecutive updates without discharge or timeout.
// - Below zero degrees charge stops at 0.94 of learned capacity.
// - Discharge events decrement nominal and increment tally; charge increments.
module capacity_learning_core (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       battery_replaced,
  input  wire [1:0] strap_pin_one,
  input  wire [1:0] strap_pin_two,
  input  wire [1:0] strap_pin_three,
  input  wire [1:0] strap_pin_four,
  input  wire [1:0] strap_pin_five,
  input  wire [1:0] display_control_pin,
  input  wire       charge_pulse,
  input  wire       discharge_pulse,
  input  wire       self_discharge_pulse,
  input  wire       filter_timeout,
  input  wire       first_empty_threshold,
  input  wire       temp_non_negative,
  input  wire [7:0] avg_cell_voltage,
  output reg  [7:0] learned_capacity,
  output reg  [7:0] nominal_capacity_count,
  output reg  [7:0] discharge_tally,
  output reg        discharge_qualified_flag,
  output reg  [7:0] scaled_energy_high,
  output reg  [7:0] scaled_energy_low,
  output wire [6:0] relative_percent,
  output wire       percent_valid,
  output reg  [2:0] count_scale,
  output reg        graphite_anode,
  output reg        self_discharge_enabled,
  output reg  [1:0] display_mode,
  output reg        capacity_learned,
  output reg        init_done
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam [1:0] ST_INIT = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  reg  [1:0]  state;
  reg  [1:0]  next_state;

  // ---------------------------------------------------------------
  // Strap decode
  // ---------------------------------------------------------------
  wire [7:0]  dec_full;
  wire [2:0]  dec_scale;
  wire        dec_graphite;
  wire        dec_sd_enable;
  wire [1:0]  dec_display_control_pin;

  strap_decoder u_straps (
    .pin_one    (strap_pin_one),
    .pin_two    (strap_pin_two),
    .pin_three  (strap_pin_three),
    .pin_four   (strap_pin_four),
    .pin_five   (strap_pin_five),
    .display_control_pin_pin   (display_control_pin),
    .full_count (dec_full),
    .scale_code (dec_scale),
    .graphite   (dec_graphite),
    .sd_enable  (dec_sd_enable),
    .display_control_pin_mode  (dec_display_control_pin)
  );

  // ---------------------------------------------------------------
  // Cycle tracking state
  // ---------------------------------------------------------------
  reg  [1:0]  charge_run;
  reg         empty_reached;
  reg         empty_seen;
  reg         temp_ok_at_empty;
  reg         charge_blocked;
  reg  [7:0]  sd_accum;

  // ---------------------------------------------------------------
  // Derived values
  // ---------------------------------------------------------------
  wire [15:0] limit_product = learned_capacity * `LIMIT_NUM;
  wire [7:0]  limit_94      = limit_product[15:`LIMIT_SHIFT];
  wire [7:0]  charge_limit;
  wire        at_full;
  wire        nac_zero;
  wire        sd_event;
  wire        drain_event;
  wire        charge_step;
  wire        valid_charge;
  wire [15:0] sd_scaled     = sd_accum * `PCT_FULL;
  wire [15:0] nac_scaled    = nominal_capacity_count * `SD_PCT;
  wire        sd_ok;
  wire        learn_ok;
  wire [7:0]  learn_value;
  wire [15:0] energy;
  wire [15:0] pct_product   = nominal_capacity_count * `PCT_FULL;

  // Cold charging stops short of full so the flag cannot set
  assign charge_limit = temp_non_negative ? learned_capacity
                                          : limit_94;
  assign at_full      = (nominal_capacity_count == learned_capacity);
  assign nac_zero     = (nominal_capacity_count == `CAP_ZERO);
  assign sd_event     = self_discharge_pulse & self_discharge_enabled;
  assign drain_event  = discharge_pulse | sd_event;
  // Discharge has priority when both pulses land together
  assign charge_step  = charge_pulse & ~drain_event;
  assign valid_charge = charge_step & (charge_run == `VALID_RUN - 2'h1)
                        & ~filter_timeout;
  assign sd_ok        = (sd_scaled < nac_scaled) | (sd_accum == `CAP_ZERO);
  assign learn_ok     = discharge_qualified_flag & ~charge_blocked
                        & temp_ok_at_empty & sd_ok;
  assign learn_value  = (discharge_tally < limit_94) ? limit_94
                                                     : discharge_tally;
  assign energy       = nominal_capacity_count * avg_cell_voltage;

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  always @* begin
    case (state)
      ST_INIT: next_state = ST_RUN;
      ST_RUN:  next_state = battery_replaced ? ST_INIT : ST_RUN;
      default: next_state = ST_INIT;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state     <= ST_INIT;
      init_done <= 1'b0;
    end else begin
      state     <= next_state;
      init_done <= (next_state == ST_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      count_scale            <= `SCALE_80;
      graphite_anode         <= 1'b0;
      self_discharge_enabled <= 1'b0;
      display_mode           <= `DISPLAY_CONTROL_PIN_OFF;
    end else if (state == ST_INIT) begin
      count_scale            <= dec_scale;
      graphite_anode         <= dec_graphite;
      self_discharge_enabled <= dec_sd_enable;
      display_mode           <= dec_display_control_pin;
    end
  end

  // ---------------------------------------------------------------
  // Valid-charge run counter
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst || state == ST_INIT) begin
      charge_run <= 2'h0;
    end else if (drain_event || filter_timeout) begin
      charge_run <= 2'h0;
    end else if (charge_step && charge_run != `BLOCK_RUN) begin
      charge_run <= charge_run + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Learned capacity
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      learned_capacity <= `CAP_ZERO;
      capacity_learned <= 1'b0;
    end else if (state == ST_INIT) begin
      learned_capacity <= dec_full;
      capacity_learned <= 1'b0;
    end else if (valid_charge && empty_reached && learn_ok) begin
      learned_capacity <= learn_value;
      capacity_learned <= 1'b1;
    end else begin
      capacity_learned <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Nominal capacity counter
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst || state == ST_INIT) begin
      nominal_capacity_count <= `CAP_ZERO;
    end else if (valid_charge && empty_reached) begin
      nominal_capacity_count <= `CAP_ZERO;
    end else if (drain_event) begin
      if (!nac_zero)
        nominal_capacity_count <= nominal_capacity_count - 8'h01;
    end else if (charge_step) begin
      if (nominal_capacity_count < charge_limit)
        nominal_capacity_count <= nominal_capacity_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Discharge tally
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst || state == ST_INIT) begin
      discharge_tally <= `CAP_ZERO;
    end else if (at_full) begin
      discharge_tally <= `CAP_ZERO;
    end else if ((discharge_pulse || (sd_event && !nac_zero)) &&
                 discharge_tally != `TALLY_MAX) begin
      discharge_tally <= discharge_tally + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Qualification tracking between full and empty
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst || state == ST_INIT) begin
      discharge_qualified_flag <= 1'b0;
      charge_blocked           <= 1'b0;
      empty_reached            <= 1'b0;
      empty_seen               <= 1'b0;
      temp_ok_at_empty         <= 1'b0;
      sd_accum                 <= `CAP_ZERO;
    end else begin
      empty_seen <= first_empty_threshold;
      if (valid_charge && empty_reached) begin
        discharge_qualified_flag <= 1'b0;
        empty_reached            <= 1'b0;
        charge_blocked           <= 1'b0;
      end else if (at_full) begin
        discharge_qualified_flag <= 1'b1;
        charge_blocked           <= 1'b0;
        sd_accum                 <= `CAP_ZERO;
      end else begin
        if (charge_step && charge_run == `VALID_RUN && !empty_reached)
          charge_blocked <= 1'b1;
        if (sd_event && sd_accum != `TALLY_MAX)
          sd_accum <= sd_accum + 8'h01;
        if (first_empty_threshold && !empty_seen && !empty_reached) begin
          empty_reached    <= 1'b1;
          temp_ok_at_empty <= temp_non_negative;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Scaled energy bytes
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      scaled_energy_high <= 8'h00;
      scaled_energy_low  <= 8'h00;
    end else begin
      scaled_energy_high <= energy[15:8];
      scaled_energy_low  <= energy[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Relative percentage remaining
  // ---------------------------------------------------------------
  percent_divider u_percent (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .dividend     (pct_product[14:0]),
    .divisor      (learned_capacity),
    .quotient     (relative_percent),
    .result_valid (percent_valid)
  );

endmodule
`default_nettype wire

// [rtl/percent_divider.v]
// Free-running restoring divider for the remaining-capacity percentage.
// Assumes a nonzero divisor; a new division starts when one ends.
`timescale 1ns/1ps
`default_nettype none
`include "capacity_learning_consts.vh"

module percent_divider (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [14:0] dividend,
  input  wire [7:0]  divisor,
  output reg  [6:0]  quotient,
  output reg         result_valid
);

  reg  [3:0]  step;
  reg  [14:0] work_num;
  reg  [8:0]  remainder;
  reg  [14:0] work_quot;
  reg  [7:0]  work_div;
  wire [8:0]  trial = {remainder[7:0], work_num[14]};
  wire        fits  = (trial >= {1'b0, work_div});

  always @(posedge sys_clk) begin
    if (rst) begin
      step         <= 4'h0;
      work_num     <= 15'h0000;
      remainder    <= 9'h000;
      work_quot    <= 15'h0000;
      work_div     <= 8'h00;
      quotient     <= 7'h00;
      result_valid <= 1'b0;
    end else if (step == 4'h0) begin
      work_num  <= dividend;
      work_div  <= divisor;
      remainder <= 9'h000;
      work_quot <= 15'h0000;
      step      <= 4'h1;
    end else begin
      remainder <= fits ? (trial - {1'b0, work_div}) : trial;
      work_num  <= {work_num[13:0], 1'b0};
      work_quot <= {work_quot[13:0], fits};
      if (step == `DIV_LAST + 4'h1) begin
        quotient     <= {work_quot[5:0], fits};
        result_valid <= 1'b1;
        step         <= 4'h0;
      end else begin
        step <= step + 4'h1;
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/strap_decoder.v]
// Combinational decode of the five program straps and display pin.
// Assumes each pin is a stable two-bit tri-level code.
`timescale 1ns/1ps
`default_nettype none
`include "capacity_learning_consts.vh"

module strap_decoder (
  input  wire [1:0] pin_one,
  input  wire [1:0] pin_two,
  input  wire [1:0] pin_three,
  input  wire [1:0] pin_four,
  input  wire [1:0] pin_five,
  input  wire [1:0] display_control_pin_pin,
  output reg  [7:0] full_count,
  output reg  [2:0] scale_code,
  output wire       graphite,
  output wire       sd_enable,
  output reg  [1:0] display_control_pin_mode
);

  // ---------------------------------------------------------------
  // Initial full count
  // ---------------------------------------------------------------
  // Second float code folds onto the plain float code
  wire [1:0] one_code = (pin_one == `TRI_ALT) ? `TRI_FLOAT : pin_one;
  wire [1:0] two_code = (pin_two == `TRI_ALT) ? `TRI_FLOAT : pin_two;

  always @* begin
    case ({one_code, two_code})
      {`TRI_HIGH,  `TRI_HIGH}:  full_count = `FULL_HH;
      {`TRI_HIGH,  `TRI_FLOAT}: full_count = `FULL_HF;
      {`TRI_HIGH,  `TRI_LOW}:   full_count = `FULL_HL;
      {`TRI_FLOAT, `TRI_HIGH}:  full_count = `FULL_FH;
      {`TRI_FLOAT, `TRI_LOW}:   full_count = `FULL_FL;
      {`TRI_LOW,   `TRI_HIGH}:  full_count = `FULL_LH;
      {`TRI_LOW,   `TRI_FLOAT}: full_count = `FULL_LF;
      {`TRI_LOW,   `TRI_LOW}:   full_count = `FULL_LL;
      default:                  full_count = `FULL_FF;
    endcase
  end

  // ---------------------------------------------------------------
  // Count scale
  // ---------------------------------------------------------------
  always @* begin
    if (pin_four == `TRI_LOW) begin
      case (pin_three)
        `TRI_HIGH: scale_code = `SCALE_80;
        `TRI_LOW:  scale_code = `SCALE_320;
        default:   scale_code = `SCALE_160;
      endcase
    end else begin
      case (pin_three)
        `TRI_HIGH: scale_code = `SCALE_640;
        `TRI_LOW:  scale_code = `SCALE_2560;
        default:   scale_code = `SCALE_1280;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Anode type, self-discharge and display
  // ---------------------------------------------------------------
  assign graphite  = (pin_five == `TRI_LOW);
  assign sd_enable = (pin_five != `TRI_HIGH);

  always @* begin
    case (display_control_pin_pin)
      `TRI_HIGH: display_control_pin_mode = `DISPLAY_CONTROL_PIN_OFF;
      `TRI_LOW:  display_control_pin_mode = `DISPLAY_CONTROL_PIN_TIMED;
      default:   display_control_pin_mode = `DISPLAY_CONTROL_PIN_CHARGING;
    endcase
  end

endmodule
`default_nettype wire

// [shared/capacity_learning_consts.vh]
// Constants for the capacity-learning counter core.
// Assumes tri-level straps arrive as two-bit codes from pad comparators.
`ifndef CAPACITY_LEARNING_CONSTS_VH
`define CAPACITY_LEARNING_CONSTS_VH

// ---------------------------------------------------------------
// Tri-level strap codes
// ---------------------------------------------------------------
`define TRI_LOW        2'h0
`define TRI_FLOAT      2'h1
`define TRI_HIGH       2'h2
`define TRI_ALT        2'h3

// ---------------------------------------------------------------
// Capacity registers hold counts in units of 256
// ---------------------------------------------------------------
`define CAP_ZERO       8'h00
`define TALLY_MAX      8'hff
// Initial full counts: 49152 .. 22528 divided by 256
`define FULL_HH        8'hc0
`define FULL_HF        8'hb0
`define FULL_HL        8'ha0
`define FULL_FH        8'h90
`define FULL_FF        8'h84
`define FULL_FL        8'h78
`define FULL_LH        8'h6c
`define FULL_LF        8'h64
`define FULL_LL        8'h58

// ---------------------------------------------------------------
// Count scale codes: 1/80 times 2 to the minus code
// ---------------------------------------------------------------
`define SCALE_80       3'h0
`define SCALE_160      3'h1
`define SCALE_320      3'h2
`define SCALE_640      3'h3
`define SCALE_1280     3'h4
`define SCALE_2560     3'h5

// ---------------------------------------------------------------
// Display modes
// ---------------------------------------------------------------
`define DISPLAY_CONTROL_PIN_OFF       2'h0
`define DISPLAY_CONTROL_PIN_CHARGING  2'h1
`define DISPLAY_CONTROL_PIN_TIMED     2'h2

// ---------------------------------------------------------------
// Arithmetic factors
// ---------------------------------------------------------------
// 241/256 stands for the 0.94 limit factor
`define LIMIT_NUM      8'hf1
`define LIMIT_SHIFT    8
`define SD_PCT         8'h06
`define PCT_FULL       8'h64
`define VALID_RUN      2'h2
`define BLOCK_RUN      2'h3
`define DIV_LAST       4'he

`endif

// [tb/front_end_model.sv]
// Analog front end: turns bench requests into one-cycle count pulses.
// Assumes requests are driven on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] req,
  input  wire logic       cell_low,
  output var  logic       charge_pulse,
  output var  logic       discharge_pulse,
  output var  logic       self_discharge_pulse,
  output var  logic       filter_timeout,
  output var  logic       first_empty_threshold
);
  always @(posedge sys_clk) begin
    if (rst) begin
      {filter_timeout, self_discharge_pulse} <= 2'h0;
      {discharge_pulse, charge_pulse} <= 2'h0;
      first_empty_threshold <= 1'b0;
    end else begin
      {filter_timeout, self_discharge_pulse} <= req[3:2];
      {discharge_pulse, charge_pulse} <= req[1:0];
      // Empty stays latched until charging resumes
      first_empty_threshold <= cell_low
        | (first_empty_threshold & ~charge_pulse);
    end
  end
endmodule
`default_nettype wire

// [tb/learning_core_sva.sv]
// Checker for the capacity-learning counter core.
// Bound to the core; sees only its ports, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module learning_core_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       battery_replaced,
  input wire logic       charge_pulse,
  input wire logic       discharge_pulse,
  input wire logic       self_discharge_pulse,
  input wire logic [7:0] avg_cell_voltage,
  input wire logic [7:0] learned_capacity,
  input wire logic [7:0] nominal_capacity_count,
  input wire logic [7:0] discharge_tally,
  input wire logic       discharge_qualified_flag,
  input wire logic [7:0] scaled_energy_high,
  input wire logic [7:0] scaled_energy_low,
  input wire logic       capacity_learned,
  input wire logic       init_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Running and not being re-initialised
  wire run = init_done & ~battery_replaced;
  // ----------------------------------------
  // Counter relations
  // ----------------------------------------
  AST_NOM_CAP: assert property (run |->
    nominal_capacity_count <= learned_capacity)
    else $error("nominal count above learned capacity");
  AST_NOM_FLOOR: assert property (run && nominal_capacity_count == 8'h00
    && !charge_pulse |=> nominal_capacity_count == 8'h00)
    else $error("nominal count went below zero");
  AST_DRAIN_STEP: assert property (run && discharge_pulse
    && !self_discharge_pulse && nominal_capacity_count != 8'h00
    && nominal_capacity_count != learned_capacity
    && discharge_tally != 8'hff |=>
    nominal_capacity_count == $past(nominal_capacity_count) - 8'h01
    && discharge_tally == $past(discharge_tally) + 8'h01)
    else $error("discharge did not step both counters");
  AST_SD_EMPTY: assert property (run && nominal_capacity_count == 8'h00
    && self_discharge_pulse && !discharge_pulse |=> $stable(discharge_tally))
    else $error("self-discharge counted at empty");
  AST_TALLY_CLEAR: assert property (run
    && nominal_capacity_count == learned_capacity |=> discharge_tally == 8'h00)
    else $error("tally not cleared at full");
  AST_TALLY_SAT: assert property (run && discharge_tally == 8'hff
    && nominal_capacity_count != learned_capacity |=> discharge_tally == 8'hff)
    else $error("tally wrapped");
  AST_FLAG_SET: assert property (run
    && nominal_capacity_count == learned_capacity |=> discharge_qualified_flag)
    else $error("qualified flag not set at full");
  AST_LEARN_ONLY: assert property ($changed(learned_capacity)
    && $past(run) && $past(run, 2) && !$past(rst) |-> capacity_learned)
    else $error("learned capacity changed without learning");
  AST_LEARN_PULSE: assert property (capacity_learned |->
    nominal_capacity_count == 8'h00 ##1 !capacity_learned)
    else $error("learning did not clear nominal count");
  AST_ENERGY: assert property (run && $past(init_done) |->
    {scaled_energy_high, scaled_energy_low} ==
    $past(nominal_capacity_count) * $past(avg_cell_voltage))
    else $error("scaled energy wrong");
  cover property (capacity_learned);
  cover property (discharge_tally == 8'hff);
  cover property (run && nominal_capacity_count == learned_capacity);
endmodule
bind capacity_learning_core learning_core_sva chk (.*);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the capacity-learning counter core.
// Assumes the core, its constants header and the front-end model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       battery_replaced = 1'b0;
  logic       temp_non_negative = 1'b1;
  logic       cell_low = 1'b0;
  logic [3:0] req = 4'h0;
  logic [7:0] avg_cell_voltage = 8'h00;
  logic [1:0] strap_pin_one = 2'h0, strap_pin_two = 2'h0;
  logic [1:0] strap_pin_three = 2'h0, strap_pin_four = 2'h0;
  logic [1:0] strap_pin_five = 2'h0, display_control_pin = 2'h0;
  wire  [7:0] learned_capacity, nominal_capacity_count, discharge_tally;
  wire  [7:0] scaled_energy_high, scaled_energy_low;
  wire  [6:0] relative_percent;
  wire  [2:0] count_scale;
  wire  [1:0] display_mode;
  wire        charge_pulse, discharge_pulse, self_discharge_pulse;
  wire        filter_timeout, first_empty_threshold, percent_valid;
  wire        discharge_qualified_flag, graphite_anode, init_done;
  wire        self_discharge_enabled, capacity_learned;
  int         bad_count = 0;
  int         n_checks = 0;
  int         lq[$];
  int         fc[9] = '{22528, 25600, 27648, 30720, 33792, 36864,
                        40960, 45056, 49152};
  int         L, tl, nom;
  capacity_learning_core uut (.*);
  front_end_model fe (.*);
  always #12.5 sys_clk = ~sys_clk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Holds a request for n cycles: n back-to-back pulses
  task automatic ev(logic [3:0] k, int n);
    @(posedge sys_clk) req <= k;
    tick(n);
    req <= 4'h0;
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One full charge, drain, empty and recharge
  task automatic cyc(int nd, int ns, bit tc, bit te, bit blk);
    int lim, top, nw;
    bit ok;
    lim = L * 241 / 256;
    top = tc ? L : lim;
    temp_non_negative <= tc;
    ev(4'h1, top + 5);
    tick(40);
    chk("nominal", top, nominal_capacity_count);
    chk("flag", top == L, discharge_qualified_flag);
    if (top == L) tl = 0;
    chk("tally", tl, discharge_tally);
    chk("percent", top * 100 / L, relative_percent);
    chk("percent_valid", 1, percent_valid);
    ev(4'h2, nd);
    if (ns > 0) ev(4'h4, ns);
    nom = top - nd - ns;
    // Tally clear wins over the first drain step taken at full
    tl = tl + nd + ns - int'(top == L);
    if (blk) begin
      ev(4'h1, 3);
      ev(4'h2, 1);
      nom = nom + 2;
      tl++;
    end
    avg_cell_voltage <= 8'($urandom);
    tick(4);
    chk("nominal", nom, nominal_capacity_count);
    chk("tally", tl, discharge_tally);
    chk("energy", nom * avg_cell_voltage,
        {scaled_energy_high, scaled_energy_low});
    temp_non_negative <= te;
    cell_low <= 1'b1;
    tick(1);
    cell_low <= 1'b0;
    tick(3);
    ok = top == L && !blk && te && (ns == 0 || ns * 100 < (nom + 2) * 6);
    nw = tl > lim ? tl : lim;
    if (ok) begin
      lq.push_back(nw);
      L = nw;
    end
    ev(4'h1, 1);
    ev(4'h8, 1);
    ev(4'h1, 1);
    ev(4'h1, 1);
    tick(4);
    chk("nominal", 0, nominal_capacity_count);
    chk("learned", L, learned_capacity);
    chk("pending", 0, lq.size());
    $display("Cycle done, learned %0d", L);
  endtask
  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (capacity_learned === 1'b1) begin
      if (lq.size() == 0) chk("unexpected_learn", 0, 1);
      else chk("learned", lq.pop_front(), learned_capacity);
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h0db2fe7f));
    tick(5);
    rst <= 1'b0;
    tick(1);
    for (int i = 8; i >= 0; i--) begin
      strap_pin_one <= 2'(i / 3);
      strap_pin_two <= 2'(i % 3);
      strap_pin_three <= 2'(i % 3);
      strap_pin_four <= 2'(i / 3);
      strap_pin_five <= 2'(i % 3);
      display_control_pin <= 2'(i % 3);
      if (i % 2) battery_replaced <= 1'b1;
      else rst <= 1'b1;
      tick(1);
      battery_replaced <= 1'b0;
      rst <= 1'b0;
      tick(3);
      for (int w = 0; w < 20 && init_done !== 1'b1; w++) tick(1);
      chk("init_done", 1, init_done);
      chk("learned", fc[i] / 256, learned_capacity);
      chk("scale", (i / 3 == 0 ? 0 : 3) + 2 - i % 3, count_scale);
      chk("graphite", i % 3 == 0, graphite_anode);
      chk("sd_on", i % 3 != 2, self_discharge_enabled);
      chk("display", 2 - i % 3, display_mode);
      chk("nominal", 0, nominal_capacity_count);
      strap_pin_one <= ~strap_pin_one;
      tick(3);
      chk("held", fc[i] / 256, learned_capacity);
    end
    $display("Strap decode done");
    L = fc[0] / 256;
    tl = 0;
    cyc(60, 0, 1, 1, 0);
    cyc(80, 0, 1, 1, 0);
    cyc(20, 0, 1, 1, 1);
    cyc(20, 0, 1, 0, 0);
    cyc(20, 5, 1, 1, 0);
    cyc(20, 0, 0, 1, 0);
    ev(4'h4, 5);
    tick(3);
    chk("tally", tl, discharge_tally);
    chk("nominal", 0, nominal_capacity_count);
    ev(4'h2, 300);
    tick(3);
    chk("tally", 255, discharge_tally);
    $display("Empty counting done");
    report_and_stop;
  end
  initial begin
    #500000;
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
